// file: core/enp_pkg.sv
// enp_pkg: constants for the per-port next-page transmit register bank
// assumes: byte-wide indirect register port, four copper ports numbered 1 to 4
package enp_pkg;
   // number of ports and their selector numbers
   localparam int NPORTS = 4;
   localparam logic [3:0] PORT_MIN = 4'h1;
   localparam logic [3:0] PORT_MAX = 4'h4;

   // direct byte addresses of the indirect scheme
   localparam logic [7:0] ADDR_SELECT = 8'h6e;
   localparam logic [7:0] ADDR_OFFSET = 8'h6f;
   localparam logic [7:0] ADDR_WINDOW = 8'ha0;

   // selector byte fields
   localparam int SEL_TABLE_HI = 7;
   localparam int SEL_TABLE_LO = 5;
   localparam int SEL_PORT_HI = 3;
   localparam logic [2:0] TABLE_EEE = 3'h1;

   // indirect offsets inside the per-port table
   localparam logic [7:0] OFF_EXP_HI = 8'h0c;
   localparam logic [7:0] OFF_EXP_LO = 8'h0d;
   localparam logic [7:0] OFF_NPT_HI = 8'h0e;
   localparam logic [7:0] OFF_NPT_LO = 8'h0f;

   // bit positions in the 16-bit transmit word
   localparam int BIT_MORE_PAGES = 15;
   localparam int BIT_RESERVED = 14;
   localparam int BIT_MESSAGE_KIND = 13;
   localparam int BIT_COMPLY_ACK = 12;
   localparam int BIT_TOGGLE = 11;
   localparam int CODE_W = 11;

   // the same fields as seen in the high byte
   localparam int HB_MORE_PAGES = 7;
   localparam int HB_MESSAGE_KIND = 5;
   localparam int HB_COMPLY_ACK = 4;
   localparam int HB_CODE_HI = 2;

   // reset values
   localparam logic RST_MORE_PAGES = 1'b0;
   localparam logic RST_MESSAGE_KIND = 1'b1;
   localparam logic RST_COMPLY_ACK = 1'b0;
   localparam logic RST_TOGGLE = 1'b0;
   localparam logic [10:0] RST_CODE = 11'h001;
   localparam logic RST_AN_ABLE = 1'b0;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// file: core/enp_port_word.sv
// enp_port_word: one port's next-page transmit codeword with its toggle bit
// assumes: byte strobes from the indirect decoder, page events from the
// negotiation engine on the same clock
`timescale 1ns/10ps
module enp_port_word (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // byte writes from the window
   input wire logic wr_hi,
   input wire logic wr_lo,
   input wire logic [7:0] wdata,
   // negotiation engine events
   input wire logic base_sent,
   input wire logic base_toggle,
   input wire logic page_sent,
   // codeword
   output logic [15:0] word
);
   logic more_pages_follow_q;
   logic message_kind_flag_q;
   logic comply_acknowledge_q;
   logic toggle_q;
   logic [enp_pkg::CODE_W-1:0] code_q;

   // high byte fields, bit 14 has no storage
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         more_pages_follow_q <= enp_pkg::RST_MORE_PAGES;
         message_kind_flag_q <= enp_pkg::RST_MESSAGE_KIND;
         comply_acknowledge_q <= enp_pkg::RST_COMPLY_ACK;
      end
      else if (wr_hi)
      begin
         more_pages_follow_q <= wdata[enp_pkg::HB_MORE_PAGES]; // [RULE_06]
         message_kind_flag_q <= wdata[enp_pkg::HB_MESSAGE_KIND]; // [RULE_12]
         comply_acknowledge_q <= wdata[enp_pkg::HB_COMPLY_ACK]; // [RULE_07]
      end
   end

   // code field, split over both bytes
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         code_q <= enp_pkg::RST_CODE; // [RULE_11]
      else
      begin
         if (wr_hi)
            code_q[10:8] <= wdata[enp_pkg::HB_CODE_HI:0]; // [RULE_11]
         if (wr_lo)
            code_q[7:0] <= wdata; // [RULE_11]
      end
   end

   // toggle: seeded from base page, then alternates per sent page
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         toggle_q <= enp_pkg::RST_TOGGLE;
      else if (base_sent)
         toggle_q <= ~base_toggle; // [RULE_09]
      else if (page_sent)
         toggle_q <= ~toggle_q; // [RULE_08] [RULE_10]
   end

   assign word = {more_pages_follow_q, 1'b0, message_kind_flag_q, comply_acknowledge_q,
                  toggle_q, code_q}; // [RULE_13]
endmodule

// file: core/enp_regs.sv
// enp_regs: indirect byte access to the per-port next-page transmit words
// assumes: host drives a byte register port on the core clock; negotiation
// engine events and partner status arrive on the same clock
//
// Function
// RULE_01 - expansion status bit 0 shows partner negotiation ability
// RULE_02 - host selects table 001 and port 1-4
// RULE_03 - host writes offset before using data window
// RULE_04 - window reads and writes the selected location
// RULE_05 - host programs word only when enabled; the code has no enable and takes window writes at any time
// RULE_06 - bit 15 says more pages follow
// RULE_07 - bit 12 says local device will comply
// RULE_08 - bit 11 inverts previous exchanged toggle
// RULE_09 - first page toggle inverts base bit 11
// RULE_10 - toggle reads 1 after sending 0
// RULE_11 - bits 10:0 are code field, reset 1
// RULE_12 - bit 13 marks message page, reset 1
// RULE_13 - reserved bit 14 reads 0, ignores writes
`timescale 1ns/10ps
module enp_regs (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // host byte register port
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   output logic bus_rvalid,
   // negotiation engine, one bit per port 1..4
   input wire logic [3:0] lp_an_able,
   input wire logic [3:0] base_sent,
   input wire logic [3:0] base_toggle,
   input wire logic [3:0] page_sent,
   // transmit codewords, port 1 in bits 15:0
   output logic [63:0] tx_words
);
   logic [7:0] select_q;
   logic [7:0] offset_q;
   logic [3:0] an_able_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [3:0] wr_hi;
   logic [3:0] wr_lo;
   logic [15:0] words [enp_pkg::NPORTS];
   logic [15:0] sel_word;
   logic sel_an_able;
   logic sel_valid;
   logic [1:0] sel_idx;
   logic win_wr;
   logic win_rd;
   logic [7:0] win_byte;

   // selector names table 001 and a port 1..4
   function automatic logic port_valid(input logic [7:0] sel);
      port_valid = (sel[enp_pkg::SEL_TABLE_HI:enp_pkg::SEL_TABLE_LO] == enp_pkg::TABLE_EEE)
         && (sel[enp_pkg::SEL_PORT_HI:0] >= enp_pkg::PORT_MIN)
         && (sel[enp_pkg::SEL_PORT_HI:0] <= enp_pkg::PORT_MAX);
   endfunction

   // zero-based port index from the selector
   function automatic logic [1:0] port_index(input logic [7:0] sel);
      logic [3:0] n;
      n = sel[enp_pkg::SEL_PORT_HI:0] - enp_pkg::PORT_MIN;
      port_index = n[1:0];
   endfunction

   assign sel_valid = port_valid(select_q); // [RULE_02]
   assign sel_idx = port_index(select_q);
   assign win_wr = bus_wr && (bus_addr == enp_pkg::ADDR_WINDOW);
   assign win_rd = bus_rd && (bus_addr == enp_pkg::ADDR_WINDOW);
   assign sel_word = words[sel_idx];
   assign sel_an_able = an_able_q[sel_idx];

   // selector byte
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         select_q <= enp_pkg::RST_BYTE;
      else if (bus_wr && (bus_addr == enp_pkg::ADDR_SELECT))
         select_q <= bus_wdata;
   end

   // offset byte, used by later window accesses
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         offset_q <= enp_pkg::RST_BYTE;
      else if (bus_wr && (bus_addr == enp_pkg::ADDR_OFFSET))
         offset_q <= bus_wdata; // [RULE_03]
   end

   // partner auto-negotiation ability, registered per port
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         an_able_q <= {enp_pkg::NPORTS{enp_pkg::RST_AN_ABLE}};
      else
         an_able_q <= lp_an_able; // [RULE_01]
   end

   // window write strobes per port
   genvar gi;
   generate
      for (gi = 0; gi < enp_pkg::NPORTS; gi++)
      begin : g_port
         assign wr_hi[gi] = win_wr && sel_valid && (sel_idx == 2'(gi))
            && (offset_q == enp_pkg::OFF_NPT_HI); // [RULE_04]
         assign wr_lo[gi] = win_wr && sel_valid && (sel_idx == 2'(gi))
            && (offset_q == enp_pkg::OFF_NPT_LO); // [RULE_04]

         enp_port_word enp_port_word_inst (
            .clock(clock),
            .nrst(nrst),
            .wr_hi(wr_hi[gi]),
            .wr_lo(wr_lo[gi]),
            .wdata(bus_wdata),
            .base_sent(base_sent[gi]),
            .base_toggle(base_toggle[gi]),
            .page_sent(page_sent[gi]),
            .word(words[gi])
         );

         assign tx_words[gi*16 +: 16] = words[gi];
      end
   endgenerate

   // window read mux; unknown table, port or offset reads zero
   always_comb
   begin
      win_byte = enp_pkg::RST_BYTE;
      if (sel_valid)
      begin
         case (offset_q)
            enp_pkg::OFF_EXP_HI: win_byte = enp_pkg::RST_BYTE;
            enp_pkg::OFF_EXP_LO: win_byte = {7'h00, sel_an_able}; // [RULE_01]
            enp_pkg::OFF_NPT_HI: win_byte = sel_word[15:8]; // [RULE_04]
            enp_pkg::OFF_NPT_LO: win_byte = sel_word[7:0]; // [RULE_04]
            default: win_byte = enp_pkg::RST_BYTE;
         endcase
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= enp_pkg::RST_BYTE;
      else if (bus_rd)
      begin
         case (bus_addr)
            enp_pkg::ADDR_SELECT: rdata_q <= select_q;
            enp_pkg::ADDR_OFFSET: rdata_q <= offset_q;
            enp_pkg::ADDR_WINDOW: rdata_q <= win_byte; // [RULE_04]
            default: rdata_q <= enp_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rvalid_q <= 1'b0;
      else
         rvalid_q <= bus_rd;
   end

   assign bus_rdata = rdata_q;
   assign bus_rvalid = rvalid_q;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   a_status_bit0: assert property ( // [RULE_01]
      win_rd && sel_valid && offset_q == enp_pkg::OFF_EXP_LO
      |=> bus_rvalid && bus_rdata == {7'h00, $past(sel_an_able)})
      else $error("status bit 0 does not show partner ability");

   a_window_hi_read: assert property ( // [RULE_04]
      win_rd && sel_valid && offset_q == enp_pkg::OFF_NPT_HI
      |=> bus_rdata == $past(sel_word[15:8]))
      else $error("window high byte differs from selected word");

   a_window_bad_sel: assert property (win_rd && !sel_valid |=> bus_rdata == 8'h00) // [RULE_04]
      else $error("window read with bad selector not zero");

   a_window_no_write: assert property ( // [RULE_04]
      win_wr && !sel_valid |-> wr_hi == 4'h0 && wr_lo == 4'h0)
      else $error("window write with bad selector reached a port");

   generate
      for (gi = 0; gi < enp_pkg::NPORTS; gi++)
      begin : g_chk
         a_more_pages_wr: assert property (wr_hi[gi] |=> // [RULE_06]
            words[gi][enp_pkg::BIT_MORE_PAGES] == $past(bus_wdata[7]))
            else $error("more pages bit not written");

         a_comply_ack_wr: assert property (wr_hi[gi] |=> // [RULE_07]
            words[gi][enp_pkg::BIT_COMPLY_ACK] == $past(bus_wdata[4]))
            else $error("comply bit not written");

         a_message_kind_wr: assert property (wr_hi[gi] |=> // [RULE_12]
            words[gi][enp_pkg::BIT_MESSAGE_KIND] == $past(bus_wdata[5]))
            else $error("message kind bit not written");

         // toggle bit left out: a page event may move it in the same cycle
         a_code_low_wr: assert property (wr_lo[gi] && !wr_hi[gi] |=> // [RULE_11]
            words[gi][7:0] == $past(bus_wdata)
            && $stable({words[gi][15:12], words[gi][10:8]}))
            else $error("code low byte not written or high byte disturbed");

         a_toggle_alternates: assert property (page_sent[gi] && !base_sent[gi] |=> // [RULE_10]
            words[gi][enp_pkg::BIT_TOGGLE] != $past(words[gi][enp_pkg::BIT_TOGGLE]))
            else $error("toggle did not alternate after sent page");

         a_toggle_first: assert property (base_sent[gi] |=> // [RULE_09]
            words[gi][enp_pkg::BIT_TOGGLE] == !$past(base_toggle[gi]))
            else $error("first toggle not inverse of base bit");

         a_toggle_hold: assert property (!page_sent[gi] && !base_sent[gi] |=> // [RULE_08]
            $stable(words[gi][enp_pkg::BIT_TOGGLE]))
            else $error("toggle moved without a page event");

         a_reserved_zero: assert property (words[gi][enp_pkg::BIT_RESERVED] == 1'b0) // [RULE_13]
            else $error("reserved bit 14 not zero");
      end
   endgenerate

   c_write_high: cover property (|wr_hi ##[1:16] win_rd);
   c_page_chain: cover property (base_sent[1] ##[1:4] page_sent[1] ##[1:4] page_sent[1]);
   c_refused_write: cover property (win_wr && !sel_valid);
   c_status_read: cover property (win_rd && sel_valid && offset_q == enp_pkg::OFF_EXP_LO);
endmodule

// file: dv/enp_host_model.sv
// enp_host_model: host processor side of the indirect byte register port
// assumes: design samples strobes on the rising clock edge, rvalid a cycle later
`timescale 1ns/10ps
module enp_host_model (
   // clock
   input wire logic clock,
   // byte register port
   output logic [7:0] bus_addr,
   output logic [7:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_rvalid
);
   initial
   begin
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
   endtask

   task automatic get(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock);
         if (bus_rvalid === 1'b1)
         begin
            d = bus_rdata;
            break;
         end
      end
   endtask

   // table, port, then offset before any window access
   task automatic pick(input logic [3:0] port, input logic [7:0] off);
      put(enp_pkg::ADDR_SELECT, {enp_pkg::TABLE_EEE, 1'b0, port});
      put(enp_pkg::ADDR_OFFSET, off);
   endtask
endmodule

// file: dv/tb_eee_next_page_tx_regs.sv
// tb_eee_next_page_tx_regs: self-checking bench for the transmit word bank
// assumes: enp_regs as top, host model on the byte port, bench drives engine
`timescale 1ns/10ps
module tb_eee_next_page_tx_regs;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] bus_addr;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata;
   logic bus_wr;
   logic bus_rd;
   logic bus_rvalid;
   logic [3:0] lp_an_able = 4'h0;
   logic [3:0] base_sent = 4'h0;
   logic [3:0] base_toggle = 4'h0;
   logic [3:0] page_sent = 4'h0;
   logic [63:0] tx_words;
   logic [15:0] exp_w [4];
   logic [7:0] rb;
   logic [7:0] bad_sel [3] = '{8'h41, 8'h20, 8'h25};
   int fail_count = 0;
   int n_compared = 0;

   always #5 clock = ~clock;

   enp_regs enp_regs_inst (.clock(clock), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .bus_rvalid(bus_rvalid), .lp_an_able(lp_an_able), .base_sent(base_sent),
      .base_toggle(base_toggle), .page_sent(page_sent), .tx_words(tx_words));
   enp_host_model enp_host_model_inst (.clock(clock), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .bus_rvalid(bus_rvalid));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_all;
      #1;
      for (int p = 0; p < 4; p++)
         chk(tx_words[16*p +: 16], exp_w[p]);
   endtask

   task automatic rd_win(input logic [3:0] port, input logic [7:0] off, input logic [7:0] e);
      enp_host_model_inst.pick(port, off);
      enp_host_model_inst.get(enp_pkg::ADDR_WINDOW, rb);
      chk({8'h00, rb}, {8'h00, e});
   endtask

   task automatic ev(input logic [3:0] b, input logic [3:0] t, input logic [3:0] pg);
      @(posedge clock);
      base_sent <= b;
      base_toggle <= t;
      page_sent <= pg;
      @(posedge clock);
      base_sent <= 4'h0;
      page_sent <= 4'h0;
      @(posedge clock);
   endtask

   task automatic t_reset;
      for (int p = 0; p < 4; p++)
         exp_w[p] = 16'h2001;
      chk_all();
      rd_win(4'h3, enp_pkg::OFF_NPT_HI, 8'h20);
      rd_win(4'h3, enp_pkg::OFF_NPT_LO, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_fields;
      for (int p = 1; p <= 4; p++)
      begin
         enp_host_model_inst.pick(p[3:0], enp_pkg::OFF_NPT_HI);
         enp_host_model_inst.put(enp_pkg::ADDR_WINDOW, 8'hff);
         enp_host_model_inst.pick(p[3:0], enp_pkg::OFF_NPT_LO);
         enp_host_model_inst.put(enp_pkg::ADDR_WINDOW, 8'h10 + p[7:0]);
         exp_w[p-1] = {8'hb7, 8'h10 + p[7:0]};
         chk_all();
         rd_win(p[3:0], enp_pkg::OFF_NPT_HI, 8'hb7);
      end
      enp_host_model_inst.pick(4'h1, enp_pkg::OFF_NPT_HI);
      enp_host_model_inst.put(enp_pkg::ADDR_WINDOW, 8'h00);
      exp_w[0][15:8] = 8'h00;
      chk_all();
      $display("test fields done");
   endtask

   task automatic t_toggle;
      ev(4'h2, 4'h2, 4'h0);
      exp_w[1][11] = 1'b0;
      chk_all();
      ev(4'h0, 4'h0, 4'h2);
      exp_w[1][11] = 1'b1;
      chk_all();
      ev(4'h0, 4'h0, 4'h2);
      exp_w[1][11] = 1'b0;
      chk_all();
      ev(4'h2, 4'h0, 4'h0);
      exp_w[1][11] = 1'b1;
      chk_all();
      rd_win(4'h2, enp_pkg::OFF_NPT_HI, exp_w[1][15:8]);
      $display("test toggle done");
   endtask

   task automatic t_status;
      @(posedge clock);
      lp_an_able <= 4'h4;
      rd_win(4'h3, enp_pkg::OFF_EXP_LO, 8'h01);
      rd_win(4'h4, enp_pkg::OFF_EXP_LO, 8'h00);
      rd_win(4'h3, enp_pkg::OFF_EXP_HI, 8'h00);
      @(posedge clock);
      lp_an_able <= 4'h0;
      rd_win(4'h3, enp_pkg::OFF_EXP_LO, 8'h00);
      $display("test status done");
   endtask

   task automatic t_refused;
      for (int i = 0; i < 3; i++)
      begin
         enp_host_model_inst.put(enp_pkg::ADDR_SELECT, bad_sel[i]);
         enp_host_model_inst.put(enp_pkg::ADDR_OFFSET, enp_pkg::OFF_NPT_LO);
         enp_host_model_inst.put(enp_pkg::ADDR_WINDOW, 8'haa);
         chk_all();
         enp_host_model_inst.get(enp_pkg::ADDR_WINDOW, rb);
         chk({8'h00, rb}, 16'h0000);
      end
      rd_win(4'h1, 8'h10, 8'h00);
      enp_host_model_inst.get(8'h55, rb);
      chk({8'h00, rb}, 16'h0000);
      $display("test refused done");
   endtask

   task automatic t_rereset;
      @(posedge clock);
      nrst <= 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      for (int p = 0; p < 4; p++)
         exp_w[p] = 16'h2001;
      @(posedge clock);
      chk_all();
      rd_win(4'h2, enp_pkg::OFF_NPT_HI, 8'h20);
      rd_win(4'h2, enp_pkg::OFF_NPT_LO, 8'h01);
      $display("test rereset done");
   endtask

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #100000;
      fail_count++;
      give_verdict();
   end

   initial
   begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_reset();
      t_fields();
      t_toggle();
      t_status();
      t_refused();
      t_rereset();
      give_verdict();
   end
endmodule
